/* hdl/psict_host.sv */
// Controller end: Wishbone registers that issue and check translated references
//
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/1ps
module psict_host (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Link to the translator
  psict_if.host link
);

  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_ISSUE = 3'b010,
    HS_WAIT = 3'b100
  } psict_hstate_t;

  typedef struct packed {
    psict_hstate_t fsm;
    logic ack;
    logic [31:0] dat;
    logic [39:0] addr;
    logic [3:0] ctrl;
    logic [8:0] status;
    logic reqStb;
    logic regStb;
    logic regSel;
    logic [31:0] regData;
    logic [31:0] resAd;
    logic [31:0] resInfo;
    logic [20:0] resIdsel;
  } psict_host_state_t;

  psict_host_state_t st_ff;
  psict_host_state_t nxt_st;

  logic access;
  logic doWrite;
  logic [31:0] wdat;
  logic [31:0] rdMux;
  logic [8:0] setBits;
  logic [8:0] clrBits;
  logic inIo;
  logic inCfg;
  logic quadEnc;
  logic encOk;
  logic typ0Hit;
  logic bridgeHit;
  logic cfgRd;

  always_comb
  begin
    access = wb_cyc_i && wb_stb_i;
    // Writes land on the edge at which the master sees ack
    doWrite = access && wb_we_i && st_ff.ack;
    wdat = 32'h00000000;
    for (int i = 0; i < 4; i++)
    begin
      wdat[i*8 +: 8] = wb_sel_i[i] ? wb_dat_i[i*8 +: 8] : 8'h00;
    end
    inIo = (st_ff.addr[39:31] == psict_pkg::SEG_IO_TOP);
    inCfg = (st_ff.addr[39:29] == psict_pkg::SEG_CFG_TOP);
    quadEnc = (st_ff.addr[6:3] == psict_pkg::LANES_QUAD);
    case (st_ff.addr[6:3])
      4'b0000, 4'b0100, 4'b1000, 4'b1100, 4'b0001, 4'b0101, 4'b1001, 4'b0110,
      4'b0010, 4'b0011, 4'b1111: encOk = 1'b1;
      default: encOk = 1'b0;
    endcase
    typ0Hit = (link.rspCmd[3:1] == 3'h5) && (link.rspAd[1:0] == 2'h0) &&
              (link.rspIdsel != 21'h000000); // [RQ15]
    bridgeHit = (link.rspCmd[3:1] == 3'h5) && (link.rspAd[1:0] == 2'h1); // [RQ18]
    cfgRd = (link.rspCmd == psict_pkg::CMD_CFG_RD);
    case (wb_adr_i)
      psict_pkg::WB_ADDR_LO: rdMux = st_ff.addr[31:0];
      psict_pkg::WB_ADDR_HI: rdMux = {24'h000000, st_ff.addr[39:32]};
      psict_pkg::WB_CTRL: rdMux = {28'h0000000, st_ff.ctrl};
      psict_pkg::WB_STATUS: rdMux = {23'h000000, st_ff.status};
      psict_pkg::WB_RES_AD: rdMux = st_ff.resAd;
      psict_pkg::WB_RES_INFO: rdMux = st_ff.resInfo;
      psict_pkg::WB_RES_IDSEL: rdMux = {11'h000, st_ff.resIdsel};
      default: rdMux = 32'h00000000;
    endcase
  end

  always_comb
  begin
    nxt_st = st_ff;
    setBits = 9'h000;
    clrBits = 9'h000;
    nxt_st.ack = access && !st_ff.ack;
    if (access && !st_ff.ack)
    begin
      nxt_st.dat = rdMux;
    end
    nxt_st.reqStb = 1'b0;
    nxt_st.regStb = 1'b0;
    if (doWrite)
    begin
      case (wb_adr_i)
        psict_pkg::WB_ADDR_LO: nxt_st.addr[31:0] = wdat;
        psict_pkg::WB_ADDR_HI: nxt_st.addr[39:32] = wdat[7:0];
        psict_pkg::WB_CTRL: nxt_st.ctrl[3:1] = wdat[3:1];
        psict_pkg::WB_RELOC:
        begin
          nxt_st.regStb = 1'b1;
          nxt_st.regSel = psict_pkg::REG_SEL_RELOC;
          nxt_st.regData = wdat;
        end
        psict_pkg::WB_CFG:
        begin
          // Reserved types are refused and never reach the translator
          if (wdat[1])
          begin
            setBits[psict_pkg::ST_E_RSVD] = 1'b1; // [RQ10]
          end
          else
          begin
            nxt_st.regStb = 1'b1;
            nxt_st.regSel = psict_pkg::REG_SEL_CFG;
            nxt_st.regData = wdat;
            setBits[psict_pkg::ST_CFG_SET] = 1'b1; // [RQ11]
          end
        end
        psict_pkg::WB_STATUS: clrBits = wdat[8:0] & 9'h1F8;
        default: nxt_st.dat = nxt_st.dat;
      endcase
    end
    case (st_ff.fsm)
      HS_IDLE:
      begin
        if (doWrite && (wb_adr_i == psict_pkg::WB_CTRL) && wdat[psict_pkg::CTRL_GO])
        begin
          if (inCfg && !st_ff.status[psict_pkg::ST_CFG_SET])
          begin
            setBits[psict_pkg::ST_E_UNSET] = 1'b1; // [RQ11]
          end
          else if (!encOk || (quadEnc != wdat[psict_pkg::CTRL_QUAD_OP]))
          begin
            setBits[psict_pkg::ST_E_ENC] = 1'b1; // [RQ7]
          end
          else if (inCfg && quadEnc && st_ff.addr[7])
          begin
            setBits[psict_pkg::ST_E_QALIGN] = 1'b1; // [RQ17]
          end
          else if (inIo && !wdat[psict_pkg::CTRL_WRITE] && (st_ff.addr[2:0] != 3'h0))
          begin
            setBits[psict_pkg::ST_E_RDLOW] = 1'b1; // [RQ20]
          end
          else
          begin
            nxt_st.fsm = HS_ISSUE;
            nxt_st.reqStb = 1'b1;
            setBits[psict_pkg::ST_BUSY] = 1'b1;
            clrBits[psict_pkg::ST_DONE] = 1'b1;
          end
        end
      end
      HS_ISSUE: nxt_st.fsm = HS_WAIT;
      HS_WAIT:
      begin
        if (link.rspStb)
        begin
          nxt_st.fsm = HS_IDLE;
          nxt_st.resAd = link.rspAd;
          nxt_st.resIdsel = link.rspIdsel;
          // Target fields: bridge bus, device, function, doubleword, then hit flags
          nxt_st.resInfo = {link.rspAd[23:16], link.rspAd[15:11], link.rspAd[10:8],
                            link.rspAd[7:2], 2'b00, bridgeHit, typ0Hit, link.rspQuad,
                            link.rspLanesOk, link.rspBeN}; // [RQ16] [RQ18]
          clrBits[psict_pkg::ST_BUSY] = 1'b1;
          setBits[psict_pkg::ST_DONE] = 1'b1;
          // A probe that nobody answers reads floating data
          if (cfgRd && !typ0Hit && !bridgeHit && st_ff.ctrl[psict_pkg::CTRL_FILL_EN])
          begin
            setBits[psict_pkg::ST_E_FILL] = 1'b1; // [RQ19]
          end
        end
      end
      default: nxt_st.fsm = HS_IDLE;
    endcase
    nxt_st.ctrl[psict_pkg::CTRL_GO] = nxt_st.fsm != HS_IDLE;
    // Set wins over a clear in the same cycle
    nxt_st.status = (st_ff.status & ~clrBits) | setBits;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st_ff <= '{
        fsm: HS_IDLE,
        ack: 1'b0,
        dat: 32'h00000000,
        addr: 40'h0000000000,
        ctrl: 4'h0,
        status: psict_pkg::ST_RST,
        reqStb: 1'b0,
        regStb: 1'b0,
        regSel: 1'b0,
        regData: 32'h00000000,
        resAd: 32'h00000000,
        resInfo: 32'h00000000,
        resIdsel: 21'h000000
      };
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign wb_dat_o = st_ff.dat;
  assign wb_ack_o = st_ff.ack;
  assign link.reqStb = st_ff.reqStb;
  assign link.reqWrite = st_ff.ctrl[psict_pkg::CTRL_WRITE];
  assign link.reqAddr = st_ff.addr;
  assign link.regStb = st_ff.regStb;
  assign link.regSel = st_ff.regSel;
  assign link.regData = st_ff.regData;

endmodule

/* hdl/psict_pkg.sv */
// Shared constants for the sparse I/O and configuration address translator
package psict_pkg;

  // ****************************************
  // Host address decode
  // ****************************************
  localparam int ADDR_W = 40;
  localparam logic [8:0] SEG_IO_TOP = 9'h10B;
  localparam logic [10:0] SEG_CFG_TOP = 11'h438;
  localparam logic [4:0] REGION_A = 5'h16;
  localparam logic [4:0] REGION_B = 5'h17;

  // ****************************************
  // Bus commands and encodings
  // ****************************************
  localparam logic [3:0] CMD_NONE = 4'h0;
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  localparam logic [3:0] LANES_QUAD = 4'hF;
  localparam logic [3:0] BE_NONE = 4'hF;
  localparam logic [1:0] CFG_TYPE0 = 2'h0;
  localparam logic [1:0] CFG_TYPE1 = 2'h1;
  localparam logic [4:0] IDSEL_LAST = 5'h14;
  localparam int IDSEL_W = 21;

  // ****************************************
  // Device registers behind the link
  // ****************************************
  localparam logic REG_SEL_RELOC = 1'b0;
  localparam logic REG_SEL_CFG = 1'b1;
  localparam int RELOC_LSB = 25;
  localparam logic [6:0] RELOC_RST = 7'h00;
  localparam logic [1:0] CFG_RST = 2'h0;

  // ****************************************
  // Controller registers on Wishbone
  // ****************************************
  localparam logic [7:0] WB_ADDR_LO = 8'h00;
  localparam logic [7:0] WB_ADDR_HI = 8'h04;
  localparam logic [7:0] WB_CTRL = 8'h08;
  localparam logic [7:0] WB_RELOC = 8'h0C;
  localparam logic [7:0] WB_CFG = 8'h10;
  localparam logic [7:0] WB_STATUS = 8'h14;
  localparam logic [7:0] WB_RES_AD = 8'h18;
  localparam logic [7:0] WB_RES_INFO = 8'h1C;
  localparam logic [7:0] WB_RES_IDSEL = 8'h20;
  localparam int CTRL_GO = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_FILL_EN = 2;
  localparam int CTRL_QUAD_OP = 3;
  localparam int ST_W = 9;
  localparam logic [ST_W-1:0] ST_RST = 9'h000;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_CFG_SET = 2;
  localparam int ST_E_RSVD = 3;
  localparam int ST_E_UNSET = 4;
  localparam int ST_E_QALIGN = 5;
  localparam int ST_E_RDLOW = 6;
  localparam int ST_E_ENC = 7;
  localparam int ST_E_FILL = 8;

endpackage

/* hdl/psict_if.sv */
// Link between the translator and its host-side controller
`timescale 1ns/1ps
interface psict_if;
  // Host request
  logic reqStb;
  logic reqWrite;
  logic [39:0] reqAddr;
  // Device register write
  logic regStb;
  logic regSel;
  logic [31:0] regData;
  // Translated bus cycle
  logic rspStb;
  logic rspHit;
  logic rspLanesOk;
  logic rspQuad;
  logic [3:0] rspCmd;
  logic [31:0] rspAd;
  logic [3:0] rspBeN;
  logic [20:0] rspIdsel;

  modport dev (
    input reqStb, reqWrite, reqAddr, regStb, regSel, regData,
    output rspStb, rspHit, rspLanesOk, rspQuad, rspCmd, rspAd, rspBeN, rspIdsel
  );
  modport host (
    output reqStb, reqWrite, reqAddr, regStb, regSel, regData,
    input rspStb, rspHit, rspLanesOk, rspQuad, rspCmd, rspAd, rspBeN, rspIdsel
  );
endinterface

/* hdl/psict_device.sv */
// Translator end: host sparse I/O and configuration references to bus cycles
//
// How it works
// [RQ1] Sparse I/O segment becomes I/O read/write
// [RQ2] Region A drives upper address bits zero
// [RQ3] Region B takes upper bits from relocation
// [RQ4] Address bits 24:3 come from host 29:8
// [RQ5] Size and offset select enables, low bits
// [RQ6] Zero enable marks lane; quadword all lanes
// [RQ7] Host uses matching load/store width only
// [RQ8] Configuration segment becomes configuration cycles
// [RQ9] Type field picks primary or bridged targets
// [RQ10] Host never writes reserved type values
// [RQ11] Host sets type before configuration access
// [RQ12] Config enables from host 6:3, low type
// [RQ13] Config host 28:7 to 23:2, top zero
// [RQ14] Device number decodes to one select bit
// [RQ15] Target answers only when selected, type zero
// [RQ16] Target picks doubleword and function from address
// [RQ17] Quadword configuration keeps register bit two zero
// [RQ18] Bridge splits bus, device, doubleword fields
// [RQ19] Software clears fill-error enable while probing
// [RQ20] Sparse reads present low address bits zero
// [RQ21] Never prefetch or read ahead sparse space
`timescale 1ns/1ps
module psict_device #(
  parameter int ADDR_W = psict_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Link to the controller
  psict_if.dev link
);

  // ****************************************
  // Parameter check
  // ****************************************
  generate
    if (ADDR_W != 40)
    begin : g_bad_width
      $error("psict_device supports a 40-bit host address only");
    end
  endgenerate

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [6:0] reloc;
    logic [1:0] cfgType;
    logic rspStb;
    logic rspHit;
    logic rspLanesOk;
    logic rspQuad;
    logic [3:0] rspCmd;
    logic [31:0] rspAd;
    logic [3:0] rspBeN;
    logic [20:0] rspIdsel;
  } psict_dev_state_t;

  psict_dev_state_t st_ff;
  psict_dev_state_t nxt_st;

  // ****************************************
  // Byte lane encoding
  // ****************************************
  // Returns {valid, byte enables}; unlisted pairs get no lanes at all, so
  // a badly encoded reference cannot corrupt bytes it never meant to touch
  function automatic logic [4:0] laneCode(input logic [1:0] size, input logic [1:0] off);
    logic [4:0] code;
    code = {1'b0, psict_pkg::BE_NONE};
    case ({size, off})
      4'b0000: code = 5'h1E; // [RQ5]
      4'b0001: code = 5'h1D;
      4'b0010: code = 5'h1B;
      4'b0011: code = 5'h17;
      4'b0100: code = 5'h1C;
      4'b0101: code = 5'h19;
      4'b0110: code = 5'h13;
      4'b1000: code = 5'h18;
      4'b1001: code = 5'h11;
      4'b1100: code = 5'h10;
      4'b1111: code = 5'h10; // [RQ6]
      default: code = {1'b0, psict_pkg::BE_NONE};
    endcase
    return code;
  endfunction

  // ****************************************
  // Device select decode
  // ****************************************
  function automatic logic [20:0] idselCode(input logic [4:0] devNum);
    logic [20:0] sel;
    sel = 21'h000000;
    if (devNum <= psict_pkg::IDSEL_LAST)
    begin
      sel[devNum] = 1'b1; // [RQ14]
    end
    return sel;
  endfunction

  // ****************************************
  // Request decode
  // ****************************************
  logic [39:0] addr;
  logic inIo;
  logic inCfg;
  logic regionA;
  logic regionB;
  logic isQuad;
  logic [4:0] lanes;
  logic [2:0] lowAd;

  always_comb
  begin
    addr = link.reqAddr;
    inIo = (addr[39:31] == psict_pkg::SEG_IO_TOP); // [RQ1]
    inCfg = (addr[39:29] == psict_pkg::SEG_CFG_TOP); // [RQ8]
    regionA = inIo && (addr[34:30] == psict_pkg::REGION_A); // [RQ2]
    regionB = inIo && (addr[34:30] == psict_pkg::REGION_B); // [RQ3]
    lanes = laneCode(addr[4:3], addr[6:5]); // [RQ12]
    isQuad = (addr[6:3] == psict_pkg::LANES_QUAD);
    // Quadword ignores bit 7 and forces the low address to zero
    lowAd = isQuad ? 3'h0 : {addr[7], 2'h0}; // [RQ6]
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    nxt_st = st_ff;
    // One answer per request and nothing extra: no read-ahead exists here
    nxt_st.rspStb = 1'b0; // [RQ21]
    if (link.regStb)
    begin
      if (link.regSel == psict_pkg::REG_SEL_RELOC)
      begin
        nxt_st.reloc = link.regData[31:psict_pkg::RELOC_LSB];
      end
      else
      begin
        nxt_st.cfgType = link.regData[1:0];
      end
    end
    if (link.reqStb)
    begin
      nxt_st.rspStb = 1'b1; // [RQ21]
      nxt_st.rspHit = 1'b0;
      nxt_st.rspLanesOk = lanes[4];
      nxt_st.rspQuad = isQuad;
      nxt_st.rspCmd = psict_pkg::CMD_NONE;
      nxt_st.rspAd = 32'h00000000;
      nxt_st.rspBeN = lanes[3:0];
      nxt_st.rspIdsel = 21'h000000;
      if (regionA || regionB)
      begin
        nxt_st.rspHit = 1'b1;
        nxt_st.rspCmd = link.reqWrite ? psict_pkg::CMD_IO_WR : psict_pkg::CMD_IO_RD; // [RQ1]
        nxt_st.rspAd[31:25] = regionB ? st_ff.reloc : 7'h00; // [RQ2] [RQ3]
        nxt_st.rspAd[24:3] = addr[29:8]; // [RQ4]
        nxt_st.rspAd[2:0] = lowAd; // [RQ5]
      end
      else if (inCfg)
      begin
        nxt_st.rspHit = 1'b1;
        nxt_st.rspCmd = link.reqWrite ? psict_pkg::CMD_CFG_WR : psict_pkg::CMD_CFG_RD; // [RQ8]
        nxt_st.rspAd[31:24] = 8'h00; // [RQ13]
        nxt_st.rspAd[23:2] = addr[28:7]; // [RQ13]
        nxt_st.rspAd[1:0] = st_ff.cfgType; // [RQ12] [RQ9]
        // Select lines only matter on the primary bus; behind a bridge the
        // device field of the type 1 address carries the choice instead
        if (st_ff.cfgType == psict_pkg::CFG_TYPE0)
        begin
          nxt_st.rspIdsel = idselCode(addr[20:16]); // [RQ14] [RQ9]
        end
      end
      else
      begin
        nxt_st.rspBeN = psict_pkg::BE_NONE;
        nxt_st.rspLanesOk = 1'b0;
        nxt_st.rspQuad = 1'b0;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st_ff <= '{
        reloc: psict_pkg::RELOC_RST,
        cfgType: psict_pkg::CFG_RST,
        rspStb: 1'b0,
        rspHit: 1'b0,
        rspLanesOk: 1'b0,
        rspQuad: 1'b0,
        rspCmd: psict_pkg::CMD_NONE,
        rspAd: 32'h00000000,
        rspBeN: psict_pkg::BE_NONE,
        rspIdsel: 21'h000000
      };
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link.rspStb = st_ff.rspStb;
  assign link.rspHit = st_ff.rspHit;
  assign link.rspLanesOk = st_ff.rspLanesOk;
  assign link.rspQuad = st_ff.rspQuad;
  assign link.rspCmd = st_ff.rspCmd;
  assign link.rspAd = st_ff.rspAd;
  assign link.rspBeN = st_ff.rspBeN;
  assign link.rspIdsel = st_ff.rspIdsel;

endmodule

/* tb/psict_monitor.sv */
// Concurrent checks on the link between translator and controller
`timescale 1ns/1ps
module psict_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Requests and register writes
  input wire logic reqStb,
  input wire logic reqWrite,
  input wire logic [39:0] reqAddr,
  input wire logic regStb,
  input wire logic regSel,
  input wire logic [31:0] regData,
  // Translated cycle
  input wire logic rspStb,
  input wire logic [3:0] rspCmd,
  input wire logic [31:0] rspAd,
  input wire logic [3:0] rspBeN,
  input wire logic [20:0] rspIdsel
);
  // Enables by {offset,size}; F where the encoding is not listed
  localparam logic [63:0] LTAB = 64'h0FF7FF3BF19D08CE;
  logic [6:0] relocFf;
  logic [1:0] cfgFf;
  logic ioHit;
  logic cfgHit;
  assign ioHit = reqAddr[39:31] == psict_pkg::SEG_IO_TOP;
  assign cfgHit = reqAddr[39:29] == psict_pkg::SEG_CFG_TOP;

  // ****************************************
  // Register mirror
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      relocFf <= psict_pkg::RELOC_RST;
      cfgFf <= psict_pkg::CFG_RST;
    end
    else if (regStb && regSel == psict_pkg::REG_SEL_RELOC)
      relocFf <= regData[31:25];
    else if (regStb)
      cfgFf <= regData[1:0];
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_rsp_follows_req: assert property (reqStb |=> rspStb)
    else $error("request not answered one cycle later");
  a_no_read_ahead: assert property (rspStb |-> $past(reqStb))
    else $error("answer without a request");
  a_io_command: assert property (reqStb && ioHit |=>
    rspCmd == ($past(reqWrite) ? psict_pkg::CMD_IO_WR : psict_pkg::CMD_IO_RD))
    else $error("wrong I/O command");
  a_region_a_top: assert property (
    reqStb && ioHit && reqAddr[34:30] == psict_pkg::REGION_A |=>
    rspAd[31:25] == 7'h00) else $error("region A upper bits not zero");
  a_region_b_top: assert property (
    reqStb && ioHit && reqAddr[34:30] == psict_pkg::REGION_B |=>
    rspAd[31:25] == $past(relocFf)) else $error("region B upper bits not relocated");
  a_io_mid_bits: assert property (reqStb && ioHit |=>
    rspAd[24:3] == $past(reqAddr[29:8])) else $error("I/O middle address bits wrong");
  a_io_lanes: assert property (reqStb && ioHit |=>
    rspBeN == LTAB[{$past(reqAddr[6:3]), 2'b00} +: 4] &&
    rspAd[2:0] == ($past(reqAddr[6:3]) == 4'hF ? 3'h0 : {$past(reqAddr[7]), 2'b00}))
    else $error("I/O lanes or low bits wrong");
  a_cfg_command: assert property (reqStb && cfgHit |=>
    rspCmd == ($past(reqWrite) ? psict_pkg::CMD_CFG_WR : psict_pkg::CMD_CFG_RD))
    else $error("wrong config command");
  a_cfg_address: assert property (reqStb && cfgHit |=>
    rspAd == {8'h00, $past(reqAddr[28:7]), $past(cfgFf)}) else $error("config address wrong");
  a_idsel_decode: assert property (
    reqStb && cfgHit && cfgFf == psict_pkg::CFG_TYPE0 |=>
    rspIdsel == (($past(reqAddr[20:16]) <= psict_pkg::IDSEL_LAST) ?
    21'h000001 << $past(reqAddr[20:16]) : 21'h000000)) else $error("select bit wrong");
endmodule

/* tb/psict_test.sv */
// Bench: both translator ends driven over Wishbone
`timescale 1ns/1ps
module psict_test;
  localparam logic [63:0] LTAB = 64'h0FF7FF3BF19D08CE;
  localparam logic [15:0] LISTED = 16'h937F;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDatI = 32'h00000000;
  logic [3:0] wbSel = 4'hF;
  logic [31:0] wbDatO;
  logic wbAck;
  logic [31:0] rd;
  logic [39:0] a;
  logic [4:0] dv;
  int errors = 0;
  int n_tests = 0;
  int nRsp = 0;
  int devs[5] = '{0, 7, 20, 21, 31};

  psict_if link();
  psict_device i_psict_device (.clock(clock), .rst_n(rst_n), .link(link.dev));
  psict_host i_psict_host (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDatI), .wb_sel_i(wbSel), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .link(link.host));
  psict_monitor i_psict_monitor (.clock(clock), .rst_n(rst_n), .reqStb(link.reqStb),
    .reqWrite(link.reqWrite), .reqAddr(link.reqAddr), .regStb(link.regStb),
    .regSel(link.regSel), .regData(link.regData), .rspStb(link.rspStb), .rspCmd(link.rspCmd),
    .rspAd(link.rspAd), .rspBeN(link.rspBeN), .rspIdsel(link.rspIdsel));

  always #2.5 clock = ~clock;
  // Counting answers shows refused orders never reach the bus
  always @(posedge clock)
    if (link.rspStb === 1'b1)
      nRsp <= nRsp + 1;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic hang(input string what);
    errors++;
    $display("BAD %s expected answer seen timeout", what);
    close_out;
  endtask

  task automatic wb(input logic [7:0] adr, input logic we, input logic [31:0] d);
    int k;
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= d;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (wbAck !== 1'b1 && k < 20);
    if (k >= 20)
      hang("wb ack");
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  // Issues one reference; w is {fill enable, write}; eb is the expected error bit, -1 for none
  task automatic op(input logic [39:0] ad, input logic [1:0] w, input logic q, input int eb);
    int n0;
    int k;
    wb(psict_pkg::WB_ADDR_LO, 1'b1, ad[31:0]);
    wb(psict_pkg::WB_ADDR_HI, 1'b1, {24'h000000, ad[39:32]});
    n0 = nRsp;
    wb(psict_pkg::WB_CTRL, 1'b1, {28'h0000000, q, w, 1'b1});
    k = 0;
    do
    begin
      wb(psict_pkg::WB_STATUS, 1'b0, 32'h00000000);
      k++;
    end
    while (rd[psict_pkg::ST_BUSY] !== 1'b0 && k < 20);
    if (k >= 20)
      hang("busy");
    chk("errors", (eb < 0) ? 6'h00 : 6'h01 << (eb - 3), rd[8:3]);
    chk("issued", eb < 0 || eb == psict_pkg::ST_E_FILL, nRsp - n0);
    wb(psict_pkg::WB_STATUS, 1'b1, 32'h000001F8);
  endtask

  task automatic rsp(input logic [3:0] c, input logic [31:0] ad, input logic [3:0] be,
    input logic [20:0] id);
    chk("cmd", c, link.rspCmd);
    chk("ad", ad, link.rspAd);
    chk("be", be, link.rspBeN);
    chk("idsel", id, link.rspIdsel);
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    chk("reset be", psict_pkg::BE_NONE, link.rspBeN);
    chk("reset cmd", psict_pkg::CMD_NONE, link.rspCmd);
    wb(psict_pkg::WB_STATUS, 1'b0, 32'h00000000);
    chk("reset status", psict_pkg::ST_RST, rd[8:0]);
    wb(8'h3C, 1'b0, 32'h00000000);
    chk("unmapped", 32'h00000000, rd);
    $display("test reset done");
    op(40'h8700010018, 1'b0, 1'b0, psict_pkg::ST_E_UNSET);
    wb(psict_pkg::WB_CFG, 1'b1, 32'h00000002);
    wb(psict_pkg::WB_STATUS, 1'b0, 32'h00000000);
    chk("reserved type", 1'b1, rd[psict_pkg::ST_E_RSVD]);
    wb(psict_pkg::WB_STATUS, 1'b1, 32'h000001F8);
    $display("test config guards done");
    for (int i = 0; i < 16; i++)
    begin
      a = {9'h10B, 1'b0, 22'h2A5A5A, 1'b1, 4'(i), 3'h0};
      op(a, 1'b0, i == 15, LISTED[i] ? -1 : psict_pkg::ST_E_ENC);
      if (LISTED[i])
        rsp(psict_pkg::CMD_IO_RD, {7'h00, a[29:8], (i == 15) ? 3'h0 : 3'h4},
          LTAB[4 * i +: 4], 21'h000000);
    end
    wb(psict_pkg::WB_RELOC, 1'b1, 32'hB4000000);
    a = {9'h10B, 1'b1, 22'h155AA5, 1'b0, 4'h3, 3'h0};
    op(a, 1'b1, 1'b0, -1);
    rsp(psict_pkg::CMD_IO_WR, {7'h5A, a[29:8], 3'h0}, 4'h0, 21'h000000);
    a = {9'h10B, 1'b0, 22'h000100, 1'b0, 4'h3, 3'h5};
    op(a, 1'b0, 1'b0, psict_pkg::ST_E_RDLOW);
    $display("test sparse I/O done");
    wb(psict_pkg::WB_CFG, 1'b1, 32'h00000000);
    foreach (devs[j])
    begin
      dv = 5'(devs[j]);
      a = {11'h438, 8'h00, dv, 8'h3C, 1'b0, 4'h3, 3'h0};
      op(a, 1'b0, 1'b0, -1);
      rsp(psict_pkg::CMD_CFG_RD, {8'h00, a[28:7], 2'b00}, 4'h0,
        (dv <= 5'h14) ? 21'h000001 << dv : 21'h000000);
    end
    // Probe of an empty slot with the fill check left on
    a = {11'h438, 8'h00, 5'h15, 16'h0018};
    op(a, 2'b10, 1'b0, psict_pkg::ST_E_FILL);
    wb(psict_pkg::WB_CFG, 1'b1, 32'h00000001);
    a = {11'h438, 8'h03, 5'h05, 8'h12, 1'b0, 4'h0, 3'h0};
    op(a, 1'b1, 1'b0, -1);
    rsp(psict_pkg::CMD_CFG_WR, {8'h00, a[28:7], 2'b01}, 4'hE, 21'h000000);
    wb(psict_pkg::WB_RES_AD, 1'b0, 32'h00000000);
    chk("result ad", {8'h00, a[28:7], 2'b01}, rd);
    wb(psict_pkg::WB_RES_INFO, 1'b0, 32'h00000000);
    chk("result info", {a[28:13], a[12:7], 2'b00, 4'h9, 4'hE}, rd);
    a = {11'h438, 8'h00, 5'h01, 8'h00, 1'b1, 4'hF, 3'h0};
    op(a, 1'b0, 1'b1, psict_pkg::ST_E_QALIGN);
    $display("test configuration done");
    op(40'h1200000018, 1'b0, 1'b0, -1);
    chk("miss hit", 1'b0, link.rspHit);
    chk("miss cmd", psict_pkg::CMD_NONE, link.rspCmd);
    $display("test outside segments done");
    close_out;
  end
endmodule
